// >>> pcieeh_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pcieeh_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Receive path
  input wire logic rx_valid,
  input wire logic rx_phy_err,
  input wire logic rx_dll_err,
  input wire logic rx_ecrc_bad,
  input wire logic rx_poisoned,
  input wire logic rx_is_cpl,
  input wire logic [1:0] rx_cpl_sts,
  input wire logic rx_deliver_q,
  input wire logic rx_drop_q,
  input wire logic retry_req_q,
  // Target path
  input wire logic tgt_req,
  input wire logic tgt_is_io,
  input wire logic tgt_wr,
  input wire logic [3:0] tgt_be,
  input wire logic tgt_reg_wr_q,
  input wire logic tgt_reg_rd_q,
  input wire logic tgt_cpl_q,
  input wire logic tgt_cpl_undef_q,
  // Master, transmit and port reset
  input wire logic mst_req_q,
  input wire logic tx_sop,
  input wire logic tx_ecrc_q,
  input wire logic port_flush_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Clean completion with a failing status; ECRC-bad ones reach the status check only with checking off
  sequence s_bad_cpl;
    rx_valid && rx_is_cpl && rx_cpl_sts != 2'h0
      && !(rx_phy_err || rx_dll_err || rx_poisoned || rx_ecrc_bad);
  endsequence
  property p_pois_held; rx_valid && rx_poisoned |=> !rx_deliver_q; endproperty
  a_pois_held: assert property (p_pois_held) else $error("poisoned TLP delivered");
  property p_ecrc_tx; tx_ecrc_q |-> $past(tx_sop); endproperty
  a_ecrc_tx: assert property (p_ecrc_tx) else $error("ECRC without packet start");
  property p_zero_wr; tgt_req && tgt_wr && !tgt_is_io && tgt_be == 4'h0
    |=> !tgt_reg_wr_q && !tgt_cpl_q; endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero-length write acted");
  property p_zero_rd; tgt_req && !tgt_wr && !tgt_is_io && tgt_be == 4'h0
    |=> tgt_cpl_q && tgt_cpl_undef_q && !tgt_reg_rd_q; endproperty
  a_zero_rd: assert property (p_zero_rd) else $error("zero-length read wrong");
  property p_low_err; rx_valid && (rx_phy_err || rx_dll_err)
    |=> !rx_deliver_q && !retry_req_q; endproperty
  a_low_err: assert property (p_low_err) else $error("lower-layer error handled above");
  property p_cpl_drop; s_bad_cpl |=> rx_drop_q && !rx_deliver_q; endproperty
  a_cpl_drop: assert property (p_cpl_drop) else $error("failed completion not dropped");
  property p_cpl_halt; s_bad_cpl |-> ##2 !mst_req_q; endproperty
  a_cpl_halt: assert property (p_cpl_halt) else $error("mastering not halted");
  property p_flush; port_flush_q
    |-> $past(psel && penable && pwrite && paddr == 8'h00 && pwdata[0]); endproperty
  a_flush: assert property (p_flush) else $error("port flush without device reset");
endmodule : pcieeh_chk
`default_nettype wire

// >>> pcieeh_defs.svh
`ifndef PCIEEH_DEFS_SVH
`define PCIEEH_DEFS_SVH
// Register byte offsets
`define PCIEEH_CTRL_OFF 8'h00
`define PCIEEH_RETRY_OFF 8'h04
`define PCIEEH_STAT_OFF 8'h08
`define PCIEEH_CAUSE_OFF 8'h0C
`define PCIEEH_MASK_OFF 8'h10
`define PCIEEH_CSTS_OFF 8'h14
`define PCIEEH_CMSK_OFF 8'h18
`define PCIEEH_USTS_OFF 8'h1C
`define PCIEEH_UMSK_OFF 8'h20
`define PCIEEH_USEV_OFF 8'h24
`define PCIEEH_FEP_OFF 8'h28
`define PCIEEH_HLOG_OFF 8'h2C
// Control fields
`define PCIEEH_C_DEVRST 0
`define PCIEEH_C_SERR 1
`define PCIEEH_C_UREN 2
`define PCIEEH_C_COREN 3
`define PCIEEH_C_NFEN 4
`define PCIEEH_C_GENEN 5
`define PCIEEH_C_CHKEN 6
`define PCIEEH_C_CTOEN 7
// Cause fields
`define PCIEEH_K_ABORT 0
`define PCIEEH_K_UNSUC 1
`define PCIEEH_K_ECRC 2
// Uncorrectable status fields
`define PCIEEH_U_POIS 0
`define PCIEEH_U_CTO 1
`define PCIEEH_U_CA 2
`define PCIEEH_U_UR 3
`define PCIEEH_U_UNEXP 4
`define PCIEEH_U_ECRC 5
// Correctable status fields
`define PCIEEH_X_ADV 0
`define PCIEEH_X_LINK 1
// Completion status codes
`define PCIEEH_CPL_SC 2'h0
`define PCIEEH_CPL_UR 2'h1
`define PCIEEH_CPL_CA 2'h2
// Reset values and the I/O all-ones read data
`define PCIEEH_CTRL_RST 8'h00
`define PCIEEH_RETRY_RST 4'h1
`define PCIEEH_MASK_RST 3'h0
`define PCIEEH_IO_ONES 32'hFFFFFFFF
`endif

// >>> pcieeh_pkg.sv
package pcieeh_pkg;
  typedef enum logic [1:0] {
    PCIEEH_ACC_NONE,
    PCIEEH_ACC_ZERO,
    PCIEEH_ACC_PART,
    PCIEEH_ACC_FULL
  } pcieeh_acc_t;
endpackage : pcieeh_pkg

// >>> pcieeh_rcm.sv
`timescale 1ns/1ns
`default_nettype none
module pcieeh_rcm (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Send request from the bench
  input wire logic go,
  input wire logic [7:0] flags,
  input wire logic [31:0] hdr,
  // Received TLP toward the device
  output logic rx_valid,
  output logic rx_phy_err,
  output logic rx_dll_err,
  output logic rx_ecrc_bad,
  output logic rx_poisoned,
  output logic rx_is_cpl,
  output logic [1:0] rx_cpl_sts,
  output logic rx_unexpected,
  output logic [31:0] rx_hdr
);
  logic [7:0] fl_q;
  logic [7:0] idle_q;
  assign {rx_unexpected, rx_cpl_sts, rx_is_cpl, rx_poisoned, rx_ecrc_bad, rx_dll_err,
    rx_phy_err} = fl_q;
  // Qualifiers churn between packets so stale flags are never trusted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_q <= 8'h00;
      fl_q <= 8'h00;
      rx_valid <= 1'b0;
      rx_hdr <= 32'h0;
    end else begin
      idle_q <= idle_q + 8'h01;
      rx_valid <= go;
      fl_q <= go ? flags : idle_q;
      rx_hdr <= go ? hdr : ~rx_hdr;
    end
  end
endmodule : pcieeh_rcm
`default_nettype wire

// >>> pcieeh_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcieeh_defs.svh"
module testbench;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, go;
  logic [7:0] paddr, flags;
  logic [31:0] pwdata, prdata, hdr, rx_hdr, seed, hl, h1;
  logic nv_ecrc_gen_cap, nv_ecrc_chk_cap, nv_mctp_ecrc, cto_event, cto_retry;
  logic rx_valid, rx_phy_err, rx_dll_err, rx_ecrc_bad, rx_poisoned, rx_is_cpl, rx_unexpected;
  logic [1:0] rx_cpl_sts;
  logic rx_deliver_q, rx_drop_q, retry_req_q, tgt_req, tgt_is_io, tgt_wr, tgt_addr_ok, tgt_ur;
  logic [3:0] tgt_be, tgt_wr_be_q;
  logic tgt_reg_wr_q, tgt_reg_rd_q, tgt_cpl_q, tgt_cpl_ones_q, tgt_cpl_undef_q;
  logic mst_req, tx_sop, tx_mctp, mst_req_q, tx_ecrc_q, err_cor_q, err_nonfatal_q;
  logic err_fatal_q, port_flush_q, irq_q;
  logic [32:0] exp_q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  pcieeh_top pcieeh_top_inst (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nv_ecrc_gen_cap, .nv_ecrc_chk_cap, .nv_mctp_ecrc, .rx_valid,
    .rx_phy_err, .rx_dll_err, .rx_ecrc_bad, .rx_poisoned, .rx_is_cpl, .rx_cpl_sts,
    .rx_unexpected, .rx_hdr, .rx_deliver_q, .rx_drop_q, .retry_req_q, .cto_event, .cto_retry,
    .tgt_req, .tgt_is_io, .tgt_wr, .tgt_be, .tgt_addr_ok, .tgt_ur, .tgt_reg_wr_q, .tgt_reg_rd_q,
    .tgt_wr_be_q, .tgt_cpl_q, .tgt_cpl_ones_q, .tgt_cpl_undef_q, .mst_req, .tx_sop, .tx_mctp,
    .mst_req_q, .tx_ecrc_q, .err_cor_q, .err_nonfatal_q, .err_fatal_q, .port_flush_q, .irq_q);
  pcieeh_rcm pcieeh_rcm_inst (.core_clk, .resetn, .go, .flags, .hdr, .rx_valid, .rx_phy_err,
    .rx_dll_err, .rx_ecrc_bad, .rx_poisoned, .rx_is_cpl, .rx_cpl_sts, .rx_unexpected, .rx_hdr);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string s, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk
  // Request held until pready is seen; settle before any level check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, rnd());
  endtask : rd
  task automatic rx(input logic [7:0] f, input logic [4:0] e, input logic [4:0] c);
    hl = rnd();
    @(posedge core_clk);
    go <= 1'b1;
    flags <= f;
    hdr <= hl;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("rx", {28'h0, e & c},
      {28'h0, c & {rx_deliver_q, rx_drop_q, retry_req_q, err_cor_q, err_nonfatal_q}});
  endtask : rx
  task automatic tg(input logic [6:0] a, input logic [8:0] e, input logic [8:0] c);
    @(posedge core_clk);
    tgt_req <= 1'b1;
    {tgt_is_io, tgt_wr, tgt_be, tgt_addr_ok} <= a;
    @(posedge core_clk);
    tgt_req <= 1'b0;
    @(negedge core_clk);
    chk("tgt", {24'h0, e & c}, {24'h0, c & {tgt_reg_wr_q, tgt_reg_rd_q, tgt_cpl_q,
      tgt_cpl_ones_q, tgt_cpl_undef_q, tgt_wr_be_q}});
  endtask : tg
  task automatic ev(input logic [1:0] a, input logic [1:0] e, input logic [1:0] c);
    @(posedge core_clk);
    {tgt_ur, cto_event} <= a;
    @(posedge core_clk);
    {tgt_ur, cto_event} <= 2'h0;
    @(negedge core_clk);
    chk("err_msg", {31'h0, e & c}, {31'h0, c & {err_cor_q, err_nonfatal_q}});
  endtask : ev
  task automatic ex(input logic m, input logic e);
    @(posedge core_clk);
    tx_sop <= 1'b1;
    tx_mctp <= m;
    @(posedge core_clk);
    tx_sop <= 1'b0;
    @(negedge core_clk);
    chk("tx_ecrc_q", {32'h0, e}, {32'h0, tx_ecrc_q});
  endtask : ex
  // Read data judged against the oldest outstanding expectation
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      chk("prdata", exp_q.pop_front(), {pslverr, prdata});
    end
  end
  // Hang guard: the full sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    {resetn, psel, penable, pwrite, go, cto_event, tgt_req, tgt_ur, tx_sop, tx_mctp} = 10'h0;
    {paddr, flags, tgt_be, tgt_is_io, tgt_wr, tgt_addr_ok} = 23'h0;
    {pwdata, hdr} = 64'h0;
    {nv_ecrc_gen_cap, nv_ecrc_chk_cap, nv_mctp_ecrc, mst_req, cto_retry} = 5'h1B;
    seed = 32'h8ED4;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`PCIEEH_STAT_OFF, 33'h1C);
    rd(`PCIEEH_RETRY_OFF, 33'h1);
    rd(8'h30, 33'h100000000);
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h08);
    rx(8'h08, 5'h06, 5'h1F);
    rd(`PCIEEH_CSTS_OFF, 33'h1);
    rd(`PCIEEH_USTS_OFF, 33'h1);
    rd(`PCIEEH_FEP_OFF, 33'h100);
    rd(`PCIEEH_HLOG_OFF, {1'b0, hl});
    h1 = hl;
    rx(8'h08, 5'h08, 5'h1D);
    rd(`PCIEEH_HLOG_OFF, {1'b0, h1});
    rd(`PCIEEH_STAT_OFF, 33'h1E);
    chk("mst_req_q", 33'h0, {32'h0, mst_req_q});
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h09);
    rd(`PCIEEH_STAT_OFF, 33'h1C);
    rd(`PCIEEH_CTRL_OFF, 33'h08);
    chk("mst_req_q", 33'h1, {32'h0, mst_req_q});
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, `PCIEEH_CTRL_OFF, g ? 32'h28 : 32'h08);
      for (int m = 0; m < 2; m++) ex(m[0], g[0] & ~m[0]);
    end
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h48);
    rx(8'h04, 5'h08, 5'h18);
    rd(`PCIEEH_CAUSE_OFF, 33'h4);
    apb(1'b1, `PCIEEH_CAUSE_OFF, 32'h4);
    for (int i = 1; i < 3; i++) begin
      rx(8'h04 | i[7:0], 5'h00, 5'h15);
      rd(`PCIEEH_CAUSE_OFF, 33'h0);
    end
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h08);
    rx(8'h04, 5'h10, 5'h18);
    apb(1'b1, `PCIEEH_MASK_OFF, 32'h1);
    for (int s = 1; s < 3; s++) begin
      rx({1'b0, s[1:0], 5'h10}, 5'h08, 5'h18);
      rd(`PCIEEH_CAUSE_OFF, 33'h3);
      chk("irq_q", 33'h1, {32'h0, irq_q});
      chk("mst_req_q", 33'h0, {32'h0, mst_req_q});
      apb(1'b1, `PCIEEH_CAUSE_OFF, 32'h3);
      chk("irq_q", 33'h0, {32'h0, irq_q});
      apb(1'b1, `PCIEEH_CTRL_OFF, 32'h09);
      chk("mst_req_q", 33'h1, {32'h0, mst_req_q});
    end
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h12);
    ev(2'h2, 2'h1, 2'h1);
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h10);
    ev(2'h2, 2'h0, 2'h1);
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h98);
    ev(2'h1, 2'h2, 2'h3);
    rx(8'h90, 5'h02, 5'h03);
    tg(7'h3F, 9'h10F, 9'h1CF);
    tg(7'h27, 9'h103, 9'h1CF);
    tg(7'h21, 9'h000, 9'h1C0);
    tg(7'h05, 9'h0C0, 9'h1F0);
    tg(7'h01, 9'h050, 9'h1F0);
    tg(7'h7E, 9'h000, 9'h180);
    tg(7'h5E, 9'h060, 9'h1E0);
    tg(7'h67, 9'h000, 9'h180);
    tg(7'h47, 9'h0C0, 9'h1E0);
    resetn <= 1'b0;
    {nv_ecrc_gen_cap, nv_ecrc_chk_cap, nv_mctp_ecrc} <= 3'h1;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`PCIEEH_STAT_OFF, 33'h30);
    apb(1'b1, `PCIEEH_CTRL_OFF, 32'h20);
    ex(1'b1, 1'b1);
    repeat (3) @(posedge core_clk);
    tally_and_finish();
  end
endmodule : testbench
bind pcieeh_top pcieeh_chk pcieeh_chk_inst (.core_clk, .resetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .rx_valid, .rx_phy_err, .rx_dll_err, .rx_ecrc_bad, .rx_poisoned, .rx_is_cpl,
  .rx_cpl_sts, .rx_deliver_q, .rx_drop_q, .retry_req_q, .tgt_req, .tgt_is_io, .tgt_wr, .tgt_be,
  .tgt_reg_wr_q, .tgt_reg_rd_q, .tgt_cpl_q, .tgt_cpl_undef_q, .mst_req_q, .tx_sop, .tx_ecrc_q,
  .port_flush_q);
`default_nettype wire

// >>> pcieeh_tgt.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcieeh_defs.svh"
module pcieeh_tgt (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Target request
  input wire logic req,
  input wire logic is_io,
  input wire logic wr,
  input wire logic [3:0] be,
  input wire logic addr_ok,
  // Register side and completion
  output logic reg_wr_q,
  output logic reg_rd_q,
  output logic [3:0] wr_be_q,
  output logic cpl_q,
  output logic cpl_ones_q,
  output logic cpl_undef_q
);
  pcieeh_pkg::pcieeh_acc_t kind;

  always_comb begin
    if (!req) begin
      kind = pcieeh_pkg::PCIEEH_ACC_NONE;
    end else if (be == 4'h0) begin
      kind = pcieeh_pkg::PCIEEH_ACC_ZERO;
    end else if (be != 4'hF) begin
      kind = pcieeh_pkg::PCIEEH_ACC_PART;
    end else begin
      kind = pcieeh_pkg::PCIEEH_ACC_FULL;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      wr_be_q <= 4'h0;
      cpl_q <= 1'b0;
      cpl_ones_q <= 1'b0;
      cpl_undef_q <= 1'b0;
    end else begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      wr_be_q <= 4'h0;
      cpl_q <= req && (!wr || is_io);
      cpl_ones_q <= 1'b0;
      cpl_undef_q <= 1'b0;
      case (kind)
        pcieeh_pkg::PCIEEH_ACC_NONE: begin
        end
        pcieeh_pkg::PCIEEH_ACC_ZERO: begin
          // No register touched except an I/O read with a good address; no error raised
          if (is_io && !addr_ok && !wr) begin
            cpl_ones_q <= 1'b1;
          end else if (!wr) begin
            cpl_undef_q <= !is_io;
            reg_rd_q <= is_io && addr_ok;
          end
        end
        pcieeh_pkg::PCIEEH_ACC_PART: begin
          if (is_io) begin
            // Partial I/O writes are dropped either way
            reg_rd_q <= !wr && addr_ok;
            cpl_ones_q <= !wr && !addr_ok;
          end else if (wr) begin
            // Byte enables honoured for partial memory writes
            reg_wr_q <= 1'b1;
            wr_be_q <= be;
          end else begin
            reg_rd_q <= 1'b1;
          end
        end
        pcieeh_pkg::PCIEEH_ACC_FULL: begin
          if (is_io && !addr_ok) begin
            cpl_ones_q <= !wr;
          end else begin
            reg_wr_q <= wr;
            wr_be_q <= wr ? be : 4'h0;
            reg_rd_q <= !wr;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule : pcieeh_tgt
`default_nettype wire

// >>> pcieeh_top.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "pcieeh_defs.svh"
// Overview of operation
// - Poisoned TLP retried up to limit, then dropped
// - Poison failure blocks mastering until port reset
// - ECRC appended only when generation enabled
// - MCTP ECRC also gated by stored bit
// - Bad ECRC packets dropped and reported
// - Check capable from store; check needs enable
// - Zero-length write changes nothing, no error
// - Partial memory read acts as full read
// - Zero-length read completes, register untouched except good-address I/O
// - I/O bad address: drop write, read ones
// - I/O partial data: drop write, read normally
// - Lower layer error suppresses higher layer reports
// - Unsuccessful completion dropped, interrupt raised
// - SERR enable also enables UR reporting
// - Advisory sets correctable status, then checks mask
// - Unmasked advisory logs status, pointer, header once
// - Advisory sends ERR_COR only, never non-fatal
// - Listed non-fatal errors handled as advisory
// - UR/CA on DMA halts mastering, sets cause
// - Device reset flushes and restores mastering
module pcieeh_top #(
  parameter int RETRY_W = 4,
  parameter int UNC_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stored configuration
  input wire logic nv_ecrc_gen_cap,
  input wire logic nv_ecrc_chk_cap,
  input wire logic nv_mctp_ecrc,
  // Received TLP
  input wire logic rx_valid,
  input wire logic rx_phy_err,
  input wire logic rx_dll_err,
  input wire logic rx_ecrc_bad,
  input wire logic rx_poisoned,
  input wire logic rx_is_cpl,
  input wire logic [1:0] rx_cpl_sts,
  input wire logic rx_unexpected,
  input wire logic [31:0] rx_hdr,
  output logic rx_deliver_q,
  output logic rx_drop_q,
  output logic retry_req_q,
  // Completion timeout
  input wire logic cto_event,
  input wire logic cto_retry,
  // Target access and target-detected UR
  input wire logic tgt_req,
  input wire logic tgt_is_io,
  input wire logic tgt_wr,
  input wire logic [3:0] tgt_be,
  input wire logic tgt_addr_ok,
  input wire logic tgt_ur,
  output logic tgt_reg_wr_q,
  output logic tgt_reg_rd_q,
  output logic [3:0] tgt_wr_be_q,
  output logic tgt_cpl_q,
  output logic tgt_cpl_ones_q,
  output logic tgt_cpl_undef_q,
  // Master requests and transmit
  input wire logic mst_req,
  input wire logic tx_sop,
  input wire logic tx_mctp,
  output logic mst_req_q,
  output logic tx_ecrc_q,
  // Messages, reset and interrupt
  output logic err_cor_q,
  output logic err_nonfatal_q,
  output logic err_fatal_q,
  output logic port_flush_q,
  output logic irq_q
);
  logic [7:0] ctrl_q;
  logic [RETRY_W-1:0] retry_lim_q;
  logic [RETRY_W-1:0] retry_cnt_q;
  logic [2:0] cause_q;
  logic [2:0] mask_q;
  logic [1:0] csts_q;
  logic [1:0] cmsk_q;
  logic [UNC_W-1:0] usts_q;
  logic [UNC_W-1:0] umsk_q;
  logic [UNC_W-1:0] usev_q;
  logic [4:0] fep_q;
  logic fep_vld_q;
  logic [31:0] hlog_q;
  logic halt_q;
  logic block_q;
  logic gen_cap_q;
  logic chk_cap_q;
  logic mctp_ecrc_q;
  logic nv_loaded_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [4:0] first_bit(input logic [UNC_W-1:0] v);
    first_bit = 5'h00;
    for (int i = UNC_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_bit = 5'(i);
      end
    end
  endfunction : first_bit

  // APB write strobe at the completing access cycle
  logic acc;
  logic wr_en;
  logic mapped;
  assign acc = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `PCIEEH_HLOG_OFF);

  // Receive classification; phy beats link beats transaction
  logic tl_ok;
  logic ecrc_fail;
  logic tl_go;
  logic pois;
  logic bad_cpl;
  logic pois_fail;
  logic soft_rst;
  assign tl_ok = rx_valid && !rx_phy_err && !rx_dll_err;
  assign ecrc_fail = tl_ok && ctrl_q[`PCIEEH_C_CHKEN] && rx_ecrc_bad;
  assign tl_go = tl_ok && !ecrc_fail;
  assign pois = tl_go && rx_poisoned;
  assign bad_cpl = tl_go && !rx_poisoned && rx_is_cpl && (rx_cpl_sts != `PCIEEH_CPL_SC);
  assign pois_fail = pois && (retry_cnt_q >= retry_lim_q);
  assign soft_rst = wr_en && hit(paddr, `PCIEEH_CTRL_OFF) && pwdata[`PCIEEH_C_DEVRST];

  // Error events by uncorrectable bit
  logic [UNC_W-1:0] ev;
  logic [UNC_W-1:0] adv_cand;
  logic [UNC_W-1:0] adv_ev;
  logic [UNC_W-1:0] plain_ev;
  logic [UNC_W-1:0] log_ev;
  logic adv_any;
  always_comb begin
    ev = '0;
    adv_cand = '0;
    ev[`PCIEEH_U_POIS] = pois;
    ev[`PCIEEH_U_CTO] = cto_event && ctrl_q[`PCIEEH_C_CTOEN];
    ev[`PCIEEH_U_CA] = bad_cpl && (rx_cpl_sts == `PCIEEH_CPL_CA);
    ev[`PCIEEH_U_UR] = (bad_cpl && (rx_cpl_sts == `PCIEEH_CPL_UR)) || tgt_ur;
    ev[`PCIEEH_U_UNEXP] = tl_go && !rx_poisoned && rx_unexpected;
    ev[`PCIEEH_U_ECRC] = ecrc_fail;
    adv_cand[`PCIEEH_U_POIS] = 1'b1;
    adv_cand[`PCIEEH_U_CTO] = cto_retry;
    adv_cand[`PCIEEH_U_CA] = 1'b1;
    adv_cand[`PCIEEH_U_UR] = !tgt_ur;
    adv_cand[`PCIEEH_U_UNEXP] = 1'b1;
  end
  assign adv_ev = ev & adv_cand & ~usev_q;
  assign plain_ev = ev & ~adv_ev;
  assign adv_any = |adv_ev;
  // Advisory logging continues only past its mask
  assign log_ev = plain_ev | (cmsk_q[`PCIEEH_X_ADV] ? '0 : adv_ev);

  // Configuration strap capture after reset release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      nv_loaded_q <= 1'b0;
      gen_cap_q <= 1'b0;
      chk_cap_q <= 1'b0;
      mctp_ecrc_q <= 1'b0;
    end else if (!nv_loaded_q) begin
      nv_loaded_q <= 1'b1;
      gen_cap_q <= nv_ecrc_gen_cap;
      chk_cap_q <= nv_ecrc_chk_cap;
      mctp_ecrc_q <= nv_mctp_ecrc;
    end
  end

  // Software registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `PCIEEH_CTRL_RST;
      retry_lim_q <= RETRY_W'(`PCIEEH_RETRY_RST);
      mask_q <= `PCIEEH_MASK_RST;
      cmsk_q <= 2'h0;
      umsk_q <= '0;
      usev_q <= '0;
    end else if (wr_en) begin
      if (hit(paddr, `PCIEEH_CTRL_OFF)) begin
        ctrl_q <= {pwdata[7:1], 1'b0};
      end
      if (hit(paddr, `PCIEEH_RETRY_OFF)) begin
        retry_lim_q <= pwdata[RETRY_W-1:0];
      end
      if (hit(paddr, `PCIEEH_MASK_OFF)) begin
        mask_q <= pwdata[2:0];
      end
      if (hit(paddr, `PCIEEH_CMSK_OFF)) begin
        cmsk_q <= pwdata[1:0];
      end
      if (hit(paddr, `PCIEEH_UMSK_OFF)) begin
        umsk_q <= pwdata[UNC_W-1:0];
      end
      if (hit(paddr, `PCIEEH_USEV_OFF)) begin
        usev_q <= pwdata[UNC_W-1:0];
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  logic [2:0] cause_set;
  assign cause_set = {ecrc_fail, bad_cpl, bad_cpl && rx_cpl_sts != `PCIEEH_CPL_SC};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cause_q <= 3'h0;
      csts_q <= 2'h0;
      usts_q <= '0;
    end else begin
      cause_q <= (cause_q & ~((wr_en && hit(paddr, `PCIEEH_CAUSE_OFF)) ?
                 pwdata[2:0] : 3'h0)) | cause_set;
      csts_q <= (csts_q & ~((wr_en && hit(paddr, `PCIEEH_CSTS_OFF)) ?
                pwdata[1:0] : 2'h0)) |
                {rx_valid && (rx_phy_err || rx_dll_err), adv_any};
      usts_q <= (usts_q & ~((wr_en && hit(paddr, `PCIEEH_USTS_OFF)) ?
                pwdata[UNC_W-1:0] : '0)) | log_ev;
    end
  end

  // First error pointer and header log hold the oldest unserviced error
  logic [UNC_W-1:0] unmasked_new;
  logic fep_clr;
  assign unmasked_new = log_ev & ~umsk_q;
  assign fep_clr = wr_en && hit(paddr, `PCIEEH_USTS_OFF) && pwdata[fep_q];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fep_q <= 5'h00;
      fep_vld_q <= 1'b0;
      hlog_q <= 32'h00000000;
    end else if ((!fep_vld_q || fep_clr) && (|unmasked_new)) begin
      fep_q <= first_bit(unmasked_new);
      fep_vld_q <= 1'b1;
      hlog_q <= rx_hdr;
    end else if (fep_clr) begin
      fep_vld_q <= 1'b0;
    end
  end

  // Poison retry and master halt
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      retry_cnt_q <= '0;
      retry_req_q <= 1'b0;
      block_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      retry_req_q <= pois && !pois_fail;
      if (pois_fail || soft_rst) begin
        retry_cnt_q <= '0;
      end else if (pois) begin
        retry_cnt_q <= retry_cnt_q + RETRY_W'(1);
      end else if (tl_go) begin
        retry_cnt_q <= '0;
      end
      // Set wins over a reset issued in the same cycle
      if (pois_fail) begin
        block_q <= 1'b1;
      end else if (soft_rst) begin
        block_q <= 1'b0;
      end
      if (cause_set[`PCIEEH_K_ABORT]) begin
        halt_q <= 1'b1;
      end else if (soft_rst) begin
        halt_q <= 1'b0;
      end
    end
  end

  // Receive delivery, master gating, transmit ECRC
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_deliver_q <= 1'b0;
      rx_drop_q <= 1'b0;
      mst_req_q <= 1'b0;
      tx_ecrc_q <= 1'b0;
      port_flush_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rx_deliver_q <= tl_go && !rx_poisoned && !bad_cpl;
      rx_drop_q <= ecrc_fail || pois_fail || bad_cpl;
      // Halt gating keeps register access alive
      mst_req_q <= mst_req && !halt_q && !block_q && !soft_rst;
      tx_ecrc_q <= tx_sop && ctrl_q[`PCIEEH_C_GENEN] &&
                   (!tx_mctp || mctp_ecrc_q);
      port_flush_q <= soft_rst;
      irq_q <= |(cause_q & mask_q);
    end
  end

  // Error messages
  logic rep_nf;
  logic rep_ur;
  assign rep_nf = ctrl_q[`PCIEEH_C_NFEN] || ctrl_q[`PCIEEH_C_SERR];
  assign rep_ur = ctrl_q[`PCIEEH_C_UREN] || ctrl_q[`PCIEEH_C_SERR];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_cor_q <= 1'b0;
      err_nonfatal_q <= 1'b0;
      err_fatal_q <= 1'b0;
    end else begin
      err_cor_q <= ctrl_q[`PCIEEH_C_COREN] &&
                   (adv_any || (rx_valid && (rx_phy_err || rx_dll_err)));
      // Advisory events never reach the non-fatal path
      err_nonfatal_q <= (|(plain_ev & ~usev_q & ~(UNC_W'(1) << `PCIEEH_U_UR)) && rep_nf) ||
                        (plain_ev[`PCIEEH_U_UR] && !usev_q[`PCIEEH_U_UR] && rep_ur);
      err_fatal_q <= (|(plain_ev & usev_q)) && rep_nf;
    end
  end

  // APB read data, one wait state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= 32'h00000000;
      if (acc && !pwrite) begin
        case (paddr)
          `PCIEEH_CTRL_OFF: prdata <= {24'h000000, ctrl_q};
          `PCIEEH_RETRY_OFF: prdata <= 32'(retry_lim_q);
          `PCIEEH_STAT_OFF: prdata <= {26'h0000000, mctp_ecrc_q, 1'b1,
                                       chk_cap_q, gen_cap_q, block_q, halt_q};
          `PCIEEH_CAUSE_OFF: prdata <= {29'h00000000, cause_q};
          `PCIEEH_MASK_OFF: prdata <= {29'h00000000, mask_q};
          `PCIEEH_CSTS_OFF: prdata <= {30'h00000000, csts_q};
          `PCIEEH_CMSK_OFF: prdata <= {30'h00000000, cmsk_q};
          `PCIEEH_USTS_OFF: prdata <= 32'(usts_q);
          `PCIEEH_UMSK_OFF: prdata <= 32'(umsk_q);
          `PCIEEH_USEV_OFF: prdata <= 32'(usev_q);
          `PCIEEH_FEP_OFF: prdata <= {23'h000000, fep_vld_q, 3'h0, fep_q};
          `PCIEEH_HLOG_OFF: prdata <= hlog_q;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Target access handling
  pcieeh_tgt u_tgt (
    .core_clk(core_clk),
    .resetn(resetn),
    .req(tgt_req),
    .is_io(tgt_is_io),
    .wr(tgt_wr),
    .be(tgt_be),
    .addr_ok(tgt_addr_ok),
    .reg_wr_q(tgt_reg_wr_q),
    .reg_rd_q(tgt_reg_rd_q),
    .wr_be_q(tgt_wr_be_q),
    .cpl_q(tgt_cpl_q),
    .cpl_ones_q(tgt_cpl_ones_q),
    .cpl_undef_q(tgt_cpl_undef_q)
  );
endmodule : pcieeh_top
`default_nettype wire
